// >>> irq_map_params.svh
// constants for the interrupt request map and vector table
`ifndef IRQ_MAP_PARAMS_SVH
`define IRQ_MAP_PARAMS_SVH

`define NUM_REQ          24
`define LEVEL_W          2
`define REQ_IDX_W        5
`define VEC_BASE         16'hFFFA
`define VEC_STEP         16'h0002
`define LEVEL_RESET      2'h3
`define REQ_EXT4         5'h00
`define REQ_EXT5         5'h01
`define REQ_EXT26        5'h02
`define REQ_EXT37        5'h03
`define REQ_TMR0_LO      5'h05
`define REQ_TMR0_HI      5'h06
`define REQ_TMR1_HI      5'h0E
`define REQ_TMR1_LO      5'h16

`endif

// >>> irq_map_pkg.sv
// types shared by the interrupt request map
package irq_map_pkg;
	typedef enum logic [1:0]
	{
		st_idle    = 2'h0,
		st_present = 2'h1,
		st_ack     = 2'h3
	} ctrl_state_t;
endpackage

// >>> level_compare.sv
// one stage of the priority tree: keeps the more urgent of two candidates
`timescale 1ns/1ps
`default_nettype none
module level_compare #(
	parameter int IDX_W = 5,
	parameter int LVL_W = 2
) (
	// candidate a, lower request number
	input  wire logic             a_valid_in,
	input  wire logic [IDX_W-1:0] a_idx_in,
	input  wire logic [LVL_W-1:0] a_lvl_in,
	// candidate b, higher request number
	input  wire logic             b_valid_in,
	input  wire logic [IDX_W-1:0] b_idx_in,
	input  wire logic [LVL_W-1:0] b_lvl_in,
	// winner
	output logic                  w_valid_out,
	output logic      [IDX_W-1:0] w_idx_out,
	output logic      [LVL_W-1:0] w_lvl_out
);
	logic take_b;

	// lower level value is more urgent; ties go to a, the lower number
	always_comb
	begin
		take_b = b_valid_in && (!a_valid_in || (b_lvl_in < a_lvl_in));
		w_valid_out = a_valid_in || b_valid_in;
		w_idx_out = take_b ? b_idx_in : a_idx_in;
		w_lvl_out = take_b ? b_lvl_in : a_lvl_in;
	end
endmodule
`default_nettype wire

// >>> irq_vector_map.sv
// interrupt source to request mapping, level arbitration and vector lookup
//
// Function
// - external channel 4 drives request 0, vector FFFA/FFFB, and wins ties at equal level.
// - external channel 5 drives request 1, vector FFF8/FFF9.
// - external channels 2 and 6 share request 2, vector FFF6/FFF7.
// - external channels 3 and 7 share request 3, vector FFF4/FFF5.
// - timer 0 lower half drives request 5 at FFF0, upper half request 6 at FFEE.
// - timer 1 upper half drives request 14, vector FFDE/FFDF.
// - timer 1 lower half drives request 22, vector FFCE/FFCF.
`include "irq_map_params.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_vector_map
	import irq_map_pkg::*;
#(
	parameter int NUM_REQ = `NUM_REQ
) (
	// clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  rstn_in,
	// named peripheral sources, level high while requesting
	input  wire logic                  ext4_irq_in,
	input  wire logic                  ext5_irq_in,
	input  wire logic                  ext2_irq_in,
	input  wire logic                  ext6_irq_in,
	input  wire logic                  ext3_irq_in,
	input  wire logic                  ext7_irq_in,
	input  wire logic                  tmr0_lo_irq_in,
	input  wire logic                  tmr0_hi_irq_in,
	input  wire logic                  tmr1_hi_irq_in,
	input  wire logic                  tmr1_lo_irq_in,
	// remaining request lines, indexed by request number
	input  wire logic [NUM_REQ-1:0]    other_req_in,
	// level fields, two bits per request, 0 most urgent, 3 disables
	input  wire logic [2*NUM_REQ-1:0]  level_fields_in,
	// cpu acknowledge of the presented request
	input  wire logic                  cpu_ack_in,
	// to the cpu core
	output logic                       irq_valid_out,
	output logic [`REQ_IDX_W-1:0]      irq_num_out,
	output logic [`LEVEL_W-1:0]        irq_level_out,
	output logic [15:0]                vec_upper_addr_out,
	output logic [15:0]                vec_lower_addr_out,
	output logic [NUM_REQ-1:0]         pending_out
);
	typedef struct packed {
		ctrl_state_t               state;
		logic                      valid;
		logic [`REQ_IDX_W-1:0]     num;
		logic [`LEVEL_W-1:0]       level;
		logic [15:0]               vec_hi;
		logic [15:0]               vec_lo;
		logic [NUM_REQ-1:0]        pending;
	} state_t;

	state_t cur;
	state_t next_cur;

	logic [NUM_REQ-1:0] req_lines;

	// tree nodes: leaves then internal, heap layout over a padded power of two
	localparam int LEAVES = 32;
	localparam int IDX_W  = `REQ_IDX_W;
	logic                  node_valid [2*LEAVES];
	logic [`REQ_IDX_W-1:0] node_idx   [2*LEAVES];
	logic [`LEVEL_W-1:0]   node_lvl   [2*LEAVES];

	// map named sources onto request numbers
	always_comb
	begin
		req_lines = other_req_in;
		req_lines[`REQ_EXT4] = ext4_irq_in;
		req_lines[`REQ_EXT5] = ext5_irq_in;
		req_lines[`REQ_EXT26] = ext2_irq_in | ext6_irq_in;
		req_lines[`REQ_EXT37] = ext3_irq_in | ext7_irq_in;
		req_lines[`REQ_TMR0_LO] = tmr0_lo_irq_in;
		req_lines[`REQ_TMR0_HI] = tmr0_hi_irq_in;
		req_lines[`REQ_TMR1_HI] = tmr1_hi_irq_in;
		req_lines[`REQ_TMR1_LO] = tmr1_lo_irq_in;
	end

	// a line competes only while its level field is not the masked value;
	// pending_out still shows the raw line so masked sources stay visible
	logic [NUM_REQ-1:0] live_req;

	always_comb
	begin
		for (int i = 0; i < NUM_REQ; i++)
		begin
			live_req[i] = req_lines[i] && (level_fields_in[2*i +: 2] != `LEVEL_RESET);
		end
	end

	genvar g;
	generate
		for (g = 0; g < LEAVES; g++)
		begin : g_leaf
			if (g < NUM_REQ)
			begin : g_real
				assign node_valid[LEAVES+g] = live_req[g];
				assign node_idx[LEAVES+g] = IDX_W'(g);
				assign node_lvl[LEAVES+g] = level_fields_in[2*g +: 2];
			end
			else
			begin : g_pad
				assign node_valid[LEAVES+g] = 1'b0;
				assign node_idx[LEAVES+g] = IDX_W'(g);
				assign node_lvl[LEAVES+g] = `LEVEL_RESET;
			end
		end
		for (g = 1; g < LEAVES; g++)
		begin : g_node
			// left child holds the lower request numbers, so ties keep the lower one
			level_compare #(
				.IDX_W (`REQ_IDX_W),
				.LVL_W (`LEVEL_W)
			) u_cmp (
				.a_valid_in  (node_valid[2*g]),
				.a_idx_in    (node_idx[2*g]),
				.a_lvl_in    (node_lvl[2*g]),
				.b_valid_in  (node_valid[2*g+1]),
				.b_idx_in    (node_idx[2*g+1]),
				.b_lvl_in    (node_lvl[2*g+1]),
				.w_valid_out (node_valid[g]),
				.w_idx_out   (node_idx[g]),
				.w_lvl_out   (node_lvl[g])
			);
		end
		assign node_valid[0] = 1'b0;
		assign node_idx[0] = '0;
		assign node_lvl[0] = '0;
	endgenerate

	// vector upper byte sits at base minus two per request number
	function automatic logic [15:0] vec_of(input logic [`REQ_IDX_W-1:0] n);
		logic [15:0] off;
		logic [15:0] vec;
		off = 16'({11'h000, n}) << 1;
		vec = 16'(`VEC_BASE - off);
		return vec;
	endfunction

	// root of the tree, taken into the state only while idle
	logic                  win_valid;
	logic [IDX_W-1:0]      win_idx;
	logic [`LEVEL_W-1:0]   win_lvl;
	logic [15:0]           win_vec_hi;
	logic [15:0]           win_vec_lo;

	always_comb
	begin
		win_valid = node_valid[1];
		win_idx = node_idx[1];
		win_lvl = node_lvl[1];
		win_vec_hi = vec_of(node_idx[1]);
		win_vec_lo = 16'(win_vec_hi + 16'h0001);
	end

	always_comb
	begin
		next_cur = cur;
		next_cur.pending = req_lines;
		case (cur.state)
			st_idle:
			begin
				if (win_valid)
				begin
					next_cur.state = st_present;
					next_cur.valid = 1'b1;
					next_cur.num = win_idx;
					next_cur.level = win_lvl;
					next_cur.vec_hi = win_vec_hi;
					next_cur.vec_lo = win_vec_lo;
				end
			end
			st_present:
			begin
				// presentation is held stable until the cpu takes it, so the
				// vector never changes under a fetch in progress
				if (cpu_ack_in)
				begin
					next_cur.state = st_ack;
					next_cur.valid = 1'b0;
				end
			end
			st_ack:
			begin
				// one idle cycle lets the source drop its request first
				next_cur.state = st_idle;
			end
			default:
			begin
				next_cur.state = st_idle;
				next_cur.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rstn_in)
		begin
			// every output reads zero while reset is held
			cur <= '0;
			cur.state <= st_idle;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	always_comb
	begin
		irq_valid_out = cur.valid;
		irq_num_out = cur.num;
		irq_level_out = cur.level;
		vec_upper_addr_out = cur.vec_hi;
		vec_lower_addr_out = cur.vec_lo;
		pending_out = cur.pending;
	end
endmodule
`default_nettype wire

// >>> ivm_cpu_model.sv
// cpu side model: takes each presented request after a set wait
`timescale 1ns/1ps
`default_nettype none
module ivm_cpu_model (
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       valid_in,
	input  wire logic [1:0] wait_in,
	output logic            ack_out
);
	logic [1:0] cnt;
	// ack drops on the edge that takes it, so one presentation gets one ack
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in || !valid_in || ack_out)
		begin
			ack_out <= 1'b0;
			cnt <= 2'h0;
		end
		else if (cnt == wait_in)
			ack_out <= 1'b1;
		else
			cnt <= cnt + 2'h1;
	end
endmodule
`default_nettype wire

// >>> irq_vector_map_assertions.sv
// concurrent checks on the request map ports
`timescale 1ns/1ps
`default_nettype none
module irq_vector_map_chk #(
	parameter int NUM_REQ = 24
) (
	// clock and reset
	input wire logic               ref_clk_in,
	input wire logic               rstn_in,
	// watched sources
	input wire logic               ext4_irq_in,
	input wire logic               ext5_irq_in,
	input wire logic               ext2_irq_in,
	input wire logic               ext6_irq_in,
	input wire logic               ext3_irq_in,
	input wire logic               ext7_irq_in,
	input wire logic               tmr0_lo_irq_in,
	input wire logic               tmr0_hi_irq_in,
	input wire logic               tmr1_hi_irq_in,
	input wire logic               tmr1_lo_irq_in,
	// watched outputs
	input wire logic               irq_valid_out,
	input wire logic [4:0]         irq_num_out,
	input wire logic [1:0]         irq_level_out,
	input wire logic [15:0]        vec_upper_addr_out,
	input wire logic [15:0]        vec_lower_addr_out,
	input wire logic [NUM_REQ-1:0] pending_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	// the first edge after reset still sees reset-time history
	chk_req0_line: assert property ($past(rstn_in) |->
		pending_out[0] == $past(ext4_irq_in)) else $error("req 0 line");
	chk_req1_line: assert property ($past(rstn_in) |->
		pending_out[1] == $past(ext5_irq_in)) else $error("req 1 line");
	chk_pair_26: assert property ($past(rstn_in) |->
		pending_out[2] == $past(ext2_irq_in | ext6_irq_in)) else $error("req 2 line");
	chk_pair_37: assert property ($past(rstn_in) |->
		pending_out[3] == $past(ext3_irq_in | ext7_irq_in)) else $error("req 3 line");
	chk_tmr0_halves: assert property ($past(rstn_in) |->
		pending_out[6:5] == $past({tmr0_hi_irq_in, tmr0_lo_irq_in})) else $error("req 5 6");
	chk_tmr1_upper: assert property ($past(rstn_in) |->
		pending_out[14] == $past(tmr1_hi_irq_in)) else $error("req 14 line");
	chk_tmr1_lower: assert property ($past(rstn_in) |->
		pending_out[22] == $past(tmr1_lo_irq_in)) else $error("req 22 line");
	chk_level_vec: assert property (irq_valid_out |-> irq_level_out != 2'h3 &&
		vec_upper_addr_out == 16'hFFFA - {10'h000, irq_num_out, 1'b0} &&
		vec_lower_addr_out == vec_upper_addr_out + 16'h0001) else $error("vector");
endmodule
bind irq_vector_map irq_vector_map_chk #(.NUM_REQ(NUM_REQ)) i_chk (
	.ref_clk_in         (ref_clk_in),
	.rstn_in            (rstn_in),
	.ext4_irq_in        (ext4_irq_in),
	.ext5_irq_in        (ext5_irq_in),
	.ext2_irq_in        (ext2_irq_in),
	.ext6_irq_in        (ext6_irq_in),
	.ext3_irq_in        (ext3_irq_in),
	.ext7_irq_in        (ext7_irq_in),
	.tmr0_lo_irq_in     (tmr0_lo_irq_in),
	.tmr0_hi_irq_in     (tmr0_hi_irq_in),
	.tmr1_hi_irq_in     (tmr1_hi_irq_in),
	.tmr1_lo_irq_in     (tmr1_lo_irq_in),
	.irq_valid_out      (irq_valid_out),
	.irq_num_out        (irq_num_out),
	.irq_level_out      (irq_level_out),
	.vec_upper_addr_out (vec_upper_addr_out),
	.vec_lower_addr_out (vec_lower_addr_out),
	.pending_out        (pending_out)
);
`default_nettype wire

// >>> tb_irq_vector_map.sv
// self-checking bench for the request map
`timescale 1ns/1ps
`default_nettype none
module tb_irq_vector_map;
	logic        ref_clk_in, rstn_in, cpu_ack_in, irq_valid_out;
	logic [10:0] src;
	logic [47:0] lvl;
	logic [1:0]  dly;
	logic [4:0]  irq_num_out;
	logic [1:0]  irq_level_out;
	logic [15:0] vec_upper_addr_out, vec_lower_addr_out;
	logic [23:0] pending_out;
	int          n_fail, checked;
	// request served by each src bit; src[10] is plain line 23
	logic [4:0] map [11] = '{5'h00, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h05, 5'h06, 5'h0E,
		5'h16, 5'h17};
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
	// plain line bits held high are the overridden ones
	irq_vector_map i_dut (.ref_clk_in, .rstn_in, .ext4_irq_in(src[0]), .ext5_irq_in(src[1]),
		.ext2_irq_in(src[2]), .ext6_irq_in(src[3]), .ext3_irq_in(src[4]), .ext7_irq_in(src[5]),
		.tmr0_lo_irq_in(src[6]), .tmr0_hi_irq_in(src[7]), .tmr1_hi_irq_in(src[8]),
		.tmr1_lo_irq_in(src[9]), .other_req_in({src[10], 23'h40406F}), .level_fields_in(lvl),
		.cpu_ack_in, .irq_valid_out, .irq_num_out, .irq_level_out, .vec_upper_addr_out,
		.vec_lower_addr_out, .pending_out);
	ivm_cpu_model i_cpu (.clk_in(ref_clk_in), .rstn_in, .valid_in(irq_valid_out),
		.wait_in(dly), .ack_out(cpu_ack_in));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	// expected vector upper byte per request number, as the map rules give it
	function automatic logic [15:0] vec_exp(input logic [4:0] n);
		case (n)
			5'h00: return 16'hFFFA;
			5'h01: return 16'hFFF8;
			5'h02: return 16'hFFF6;
			5'h03: return 16'hFFF4;
			5'h05: return 16'hFFF0;
			5'h06: return 16'hFFEE;
			5'h0E: return 16'hFFDE;
			5'h16: return 16'hFFCE;
			5'h17: return 16'hFFCC;
			default: return 16'h0000;
		endcase
	endfunction
	task automatic await(input logic v);
		int t = 0;
		do
		begin
			@(posedge ref_clk_in);
			#1;
			t++;
		end
		while (irq_valid_out !== v && t < 20);
		`CHK(irq_valid_out, v)
	endtask
	// serves n requests in the order packed in o, dropping each source the cycle after it is presented
	task automatic serve(input logic [10:0] m, input logic [47:0] lv, input logic [44:0] o,
		input int n, input logic [1:0] d);
		logic [10:0] s;
		logic [4:0] num;
		@(posedge ref_clk_in);
		src <= m;
		lvl <= lv;
		dly <= d;
		for (int k = 0; k < n; k++)
		begin
			num = o[5*k +: 5];
			await(1'b1);
			`CHK(irq_num_out, num)
			`CHK(vec_upper_addr_out, vec_exp(num))
			`CHK(vec_lower_addr_out, 16'(vec_exp(num) + 16'h0001))
			`CHK(irq_level_out, lv[2*num +: 2])
			s = src;
			for (int j = 0; j < 11; j++)
				if (map[j] == num)
					s[j] = 1'b0;
			@(posedge ref_clk_in);
			src <= s;
			await(1'b0);
		end
	endtask
	task single_sources;
		for (int i = 0; i < 11; i++)
			serve(11'h001 << i, 48'h0, {40'h0, map[i]}, 1, 2'h0);
	endtask
	task tie_order;
		serve(11'h7FF, 48'h0, {5'h17, 5'h16, 5'h0E, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01, 5'h00},
			9, 2'h3);
	endtask
	task level_order;
		serve(11'h7FF, {2'h0, {22{2'h1}}, 2'h3}, {5'h00, 5'h16, 5'h0E, 5'h06, 5'h05, 5'h03,
			5'h02, 5'h01, 5'h17}, 8, 2'h1);
		repeat (6) @(posedge ref_clk_in);
		#1;
		`CHK(irq_valid_out, 1'b0)
		`CHK(pending_out[0], 1'b1)
		@(posedge ref_clk_in);
		src <= 11'h000;
	endtask
	// reset in mid-presentation clears every output, then the held request returns
	task reset_midway;
		@(posedge ref_clk_in);
		src <= 11'h002;
		lvl <= 48'h0;
		dly <= 2'h3;
		await(1'b1);
		`CHK(irq_num_out, 5'h01)
		@(posedge ref_clk_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1;
		`CHK({irq_valid_out, irq_num_out, irq_level_out, pending_out}, 32'h0)
		`CHK({vec_upper_addr_out, vec_lower_addr_out}, 32'h0)
		@(posedge ref_clk_in);
		rstn_in <= 1'b1;
		serve(11'h002, 48'h0, {40'h0, 5'h01}, 1, 2'h0);
	endtask
	task give_verdict;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		n_fail++;
		give_verdict();
	end
	initial
	begin
		n_fail = 0;
		checked = 0;
		rstn_in = 1'b0;
		src = 11'h000;
		lvl = 48'h0;
		dly = 2'h0;
		repeat (3) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		single_sources();
		tie_order();
		level_order();
		reset_midway();
		give_verdict();
	end
endmodule
`default_nettype wire
